// ===== sim/sfsrb_bank_properties.sv
// Purpose: Port-level properties of the register bank.
// Assumes: One core clock domain, synchronous active-low reset.
// Notes: Level inputs settle through two flops, so holds span 7 or 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module sfsrb_bank_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic miso,
  input wire logic key_switch_in,
  input wire logic pre_shutdown_in,
  input wire logic overvoltage_reset,
  input wire logic undervoltage_reset,
  input wire logic watchdog_reset,
  input wire logic software_reset,
  input wire logic [sfsrb_pkg::NOUT-1:0] low_side_output,
  input wire logic [sfsrb_pkg::NOUT-1:0] drain_high,
  input wire logic [sfsrb_pkg::NOUT-1:0] overcurrent_fault,
  input wire logic [sfsrb_pkg::NIND-1:0] on_indicator,
  input wire logic system_any_fault
);
  import sfsrb_pkg::*;
  logic src_any;
  logic [3:0] quiet_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Any reset source
  assign src_any = overvoltage_reset | undervoltage_reset | watchdog_reset | software_reset;
  // Cycles with a frame open and no reset source
  always_ff @(posedge clk) begin
    if (!rst_b || chip_select_n || src_any) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence s_src_held;
    src_any [*7];
  endsequence
  sequence s_oc_held;
    (|overcurrent_fault && !src_any) [*8];
  endsequence
  sequence s_short_held;
    (|(drain_high & low_side_output) && !src_any) [*8];
  endsequence
  a_reset_quiet: assert property (
    $rose(rst_b) |-> on_indicator == 8'h00 && !system_any_fault && !miso)
    else $error("outputs not cleared by reset");
  a_src_blocks_ind: assert property (s_src_held |-> on_indicator == 8'h00)
    else $error("indicator on during reset source");
  a_key_off_dark: assert property (
    (!key_switch_in && !pre_shutdown_in) [*7] |-> on_indicator == 8'h00)
    else $error("indicator on outside normal state");
  a_relay2_only: assert property (
    !key_switch_in [*7] |-> (on_indicator & 8'hF7) == 8'h00)
    else $error("indicator other than relay two on");
  a_fault_sticky: assert property (quiet_q > 4'h7 |-> !$fell(system_any_fault))
    else $error("fault summary dropped without clear");
  a_oc_sets_sum: assert property (s_oc_held |-> system_any_fault)
    else $error("overcurrent not summarised");
  a_short_sets_sum: assert property (s_short_held |-> system_any_fault)
    else $error("short to battery not summarised");
  for (genvar g = 0; g < NIND; g++) begin : g_ind
    a_fault_blocks_ind: assert property (
      overcurrent_fault[IND_OUT[g]] [*7] |-> !on_indicator[g])
      else $error("indicator on despite overcurrent");
  end
endmodule
bind sfsrb_bank sfsrb_bank_properties u_props (.clk(clk), .rst_b(rst_b),
  .chip_select_n(chip_select_n), .miso(miso), .key_switch_in(key_switch_in),
  .pre_shutdown_in(pre_shutdown_in), .overvoltage_reset(overvoltage_reset),
  .undervoltage_reset(undervoltage_reset), .watchdog_reset(watchdog_reset),
  .software_reset(software_reset), .low_side_output(low_side_output),
  .drain_high(drain_high), .overcurrent_fault(overcurrent_fault),
  .on_indicator(on_indicator), .system_any_fault(system_any_fault));
`default_nettype wire

// ===== sim/sfsrb_bank_tb_top.sv
// Purpose: Self-checking bench for the fault and status register bank.
// Assumes: Levels change at falling clock edges; frames from the host model.
// Notes: A read is collected by a following check frame.
`timescale 1ns/1ps
`default_nettype none
module sfsrb_bank_tb_top;
  import sfsrb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic stm = 1'b0, key = 1'b1, pre = 1'b0, ph = 1'b0, sw = 1'b0;
  logic ov = 1'b0, uv = 1'b0, wd = 1'b0;
  logic [NIND-1:0] pin = '0;
  logic [NOUT-1:0] lso = '0, dl = '0, dh = '0, oc = '0, ot = '0, sg = '0;
  logic link_clk, chip_select_n, mosi, miso, system_any_fault;
  logic [NIND-1:0] on_indicator;
  logic [15:0] r;
  int num_errors = 0;
  int checked = 0;
  sfsrb_host_model host (.link_clk(link_clk), .chip_select_n(chip_select_n),
    .mosi(mosi), .miso(miso));
  sfsrb_bank dut (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .self_test_write_mode(stm),
    .key_switch_in(key), .pre_shutdown_in(pre), .power_hold_enable(ph),
    .overvoltage_reset(ov), .undervoltage_reset(uv), .watchdog_reset(wd),
    .software_reset(sw), .cmd_pin(pin), .low_side_output(lso), .drain_low(dl),
    .drain_high(dh), .overcurrent_fault(oc), .overtemp_fault(ot),
    .short_ground_fault(sg), .on_indicator(on_indicator),
    .system_any_fault(system_any_fault));
  // Core clock
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Send a frame, collect its answer with a check frame
  task automatic ask(input logic [15:0] f, input logic [15:0] exp);
    host.xfer(f, r);
    host.xfer(16'h0000, r);
    check(r, exp);
  endtask
  task automatic t_link();
    ask(16'h0ABC, 16'h7ABC);
    ask(16'h7ABC, 16'h0000);
    ask(16'h9123, 16'h0000);
    ask(16'h1000, 16'h1010);
    ask(16'h23FF, 16'h23DF);
    ask(16'h1300, 16'h13DF);
    ask(16'h1F00, 16'h1F00);
    ask(16'h5A00, 16'h5A00);
    $display("link test done");
  endtask
  task automatic t_fault();
    host.xfer(16'h6280, r);
    idle(1);
    pin <= 8'h01;
    idle(12);
    check(on_indicator, 8'h05);
    oc[2] <= 1'b1;
    idle(12);
    oc[2] <= 1'b0;
    idle(12);
    check(on_indicator, 8'h01);
    check(system_any_fault, 1'b1);
    ask(16'h3D00, 16'h3D80);
    ask(16'h3200, 16'h3282);
    ask(16'h4202, 16'h4282);
    idle(12);
    check(system_any_fault, 1'b0);
    check(on_indicator, 8'h05);
    sw <= 1'b1;
    idle(12);
    check(on_indicator, 8'h00);
    sw <= 1'b0;
    $display("fault test done");
  endtask
  task automatic t_short();
    lso[1] <= 1'b1;
    dh[1] <= 1'b1;
    dl <= 9'h003;
    idle(12);
    lso <= '0;
    dh <= '0;
    dl <= '0;
    idle(4);
    ask(16'h3100, 16'h3182);
    ask(16'h3000, 16'h3081);
    ask(16'h2000, 16'h2000);
    ask(16'h3000, 16'h3000);
    ask(16'h4001, 16'h4000);
    idle(1);
    stm <= 1'b1;
    ask(16'h410C, 16'h4182);
    ask(16'h3100, 16'h318C);
    idle(1);
    stm <= 1'b0;
    ask(16'h410F, 16'h418C);
    idle(12);
    check(system_any_fault, 1'b0);
    $display("short test done");
  endtask
  task automatic t_relay2();
    host.xfer(16'h2340, r);
    host.xfer(16'h6380, r);
    idle(1);
    key <= 1'b0;
    idle(8);
    pre <= 1'b1;
    ph <= 1'b1;
    idle(12);
    check(on_indicator, 8'h08);
    ph <= 1'b0;
    host.xfer(16'h6200, r);
    idle(12);
    check(on_indicator, 8'h00);
    key <= 1'b1;
    pre <= 1'b0;
    idle(12);
    check(on_indicator, 8'h0D);
    ask(16'h3C00, 16'h3C0D);
    $display("relay test done");
  endtask
  task automatic t_mode();
    host.xfer(16'h2001, r);
    idle(1);
    check(on_indicator, 8'h0C);
    host.xfer(16'h6001, r);
    idle(1);
    check(on_indicator, 8'h0D);
    host.xfer(16'h2005, r);
    idle(1);
    check(on_indicator, 8'h0C);
    host.xfer(16'h6081, r);
    idle(1);
    check(on_indicator, 8'h0D);
    $display("mode test done");
  endtask
  task automatic t_ground();
    sg <= 9'h012;
    ot <= 9'h0A0;
    idle(12);
    sg <= '0;
    ot <= '0;
    idle(4);
    check(system_any_fault, 1'b1);
    ask(16'h3100, 16'h3188);
    ask(16'h3400, 16'h3400);
    ask(16'h3500, 16'h3584);
    ask(16'h3800, 16'h3800);
    ask(16'h4108, 16'h4188);
    ask(16'h4504, 16'h4584);
    idle(12);
    check(system_any_fault, 1'b0);
    $display("ground test done");
  endtask
  task automatic t_ident();
    ask(16'h3F00, 16'h3F52);
    ask(16'h4FFF, 16'h4F52);
    ask(16'h3F00, 16'h3F52);
    $display("ident test done");
  endtask
  // Main sequence
  initial begin
    idle(8);
    rst_b <= 1'b1;
    idle(8);
    t_link();
    t_fault();
    t_short();
    t_relay2();
    t_mode();
    t_ground();
    t_ident();
    conclude();
  end
  // Hang guard
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ===== sim/sfsrb_host_model.sv
// Purpose: Host side of the frame link.
// Assumes: Link clock of 160 ns that runs only inside frames.
// Notes: Between frames the data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module sfsrb_host_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso
);
  // Idle link
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  // One whole frame; answer bit taken before each rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #40;
      rx[i] = miso;
      #40 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== src/sfsrb_bank.sv
// Purpose: Register bank behind a 16-bit SPI frame link, with sticky
//          fault bits, summaries and output on/off indicators.
// Assumes: Comparator and fault inputs are asynchronous levels.
// Notes: Frames execute a few core cycles after chip select rises.
`timescale 1ns/1ps
`default_nettype none
module sfsrb_bank (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  input wire logic self_test_write_mode,
  input wire logic key_switch_in,
  input wire logic pre_shutdown_in,
  input wire logic power_hold_enable,
  input wire logic overvoltage_reset,
  input wire logic undervoltage_reset,
  input wire logic watchdog_reset,
  input wire logic software_reset,
  input wire logic [sfsrb_pkg::NIND-1:0] cmd_pin,
  input wire logic [sfsrb_pkg::NOUT-1:0] low_side_output,
  input wire logic [sfsrb_pkg::NOUT-1:0] drain_low,
  input wire logic [sfsrb_pkg::NOUT-1:0] drain_high,
  input wire logic [sfsrb_pkg::NOUT-1:0] overcurrent_fault,
  input wire logic [sfsrb_pkg::NOUT-1:0] overtemp_fault,
  input wire logic [sfsrb_pkg::NOUT-1:0] short_ground_fault,
  output logic [sfsrb_pkg::NIND-1:0] on_indicator,
  output logic system_any_fault
);
  import sfsrb_pkg::*;

  logic [NASYNC-1:0] async_in;
  logic [NASYNC-1:0] meta_q;
  logic [NASYNC-1:0] sync_q;
  logic cs_m_q;
  logic cs_s_q;
  logic cs_d_q;
  logic link_clr_q;
  logic [15:0] resp_q;
  logic [15:0] rx_word;
  logic [4:0] rx_count;
  logic self_test_s;
  logic key_sw_s;
  logic pre_shut_s;
  logic power_hold_s;
  logic any_reset_s;
  logic [NIND-1:0] cmd_pin_s;
  logic [NOUT-1:0] on_s;
  logic [NOUT-1:0] dlow_s;
  logic [NOUT-1:0] dhigh_s;
  logic [NOUT-1:0] oc_s;
  logic [NOUT-1:0] ot_s;
  logic [NOUT-1:0] sg_s;
  logic take;
  logic frame_done;
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] cfg_q [NREG];
  logic [7:0] ctrl_q [NREG];
  logic [3:0] flt_q [NOUT];
  logic [NIND-1:0] ind_d;
  logic [NIND-1:0] ind_q;
  logic sys_any_q;
  logic sys_any_d;
  logic [7:0] stat_rd;
  logic [7:0] rd_val;
  logic [15:0] resp_d;
  logic stat_wr;

  // Link-side shifter on its own clock
  sfsrb_spi_link u_link (
    .link_clk(link_clk),
    .link_clr(link_clr_q),
    .chip_select_n(chip_select_n),
    .mosi(mosi),
    .resp_word(resp_q),
    .rx_word(rx_word),
    .rx_count(rx_count),
    .miso(miso)
  );

  // All pin levels enter through two flip-flops; field order
  // must match the unpack below, highest bits first
  assign async_in = {self_test_write_mode, key_switch_in, pre_shutdown_in,
                     power_hold_enable,
                     overvoltage_reset | undervoltage_reset,
                     watchdog_reset, software_reset, cmd_pin,
                     low_side_output, drain_low, drain_high,
                     overcurrent_fault, overtemp_fault, short_ground_fault};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  // Unpack synchronised levels
  always_comb begin
    self_test_s = sync_q[NASYNC-1];
    key_sw_s = sync_q[NASYNC-2];
    pre_shut_s = sync_q[NASYNC-3];
    power_hold_s = sync_q[NASYNC-4];
    any_reset_s = |sync_q[NASYNC-5 -: 3];
    cmd_pin_s = sync_q[6*NOUT +: NIND];
    on_s = sync_q[5*NOUT +: NOUT];
    dlow_s = sync_q[4*NOUT +: NOUT];
    dhigh_s = sync_q[3*NOUT +: NOUT];
    oc_s = sync_q[2*NOUT +: NOUT];
    ot_s = sync_q[NOUT +: NOUT];
    sg_s = sync_q[0 +: NOUT];
  end

  // Chip select synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
    end else begin
      cs_m_q <= chip_select_n;
      cs_s_q <= cs_m_q;
    end
  end

  // Delayed select for the rise detector; idle high avoids a false rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_d_q <= 1'b1;
    end else begin
      cs_d_q <= cs_s_q;
    end
  end

  // Bit count cleared once the frame has been taken, until select falls
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_clr_q <= 1'b1;
    end else begin
      link_clr_q <= cs_s_q & cs_d_q;
    end
  end

  // Frame decode; link words are stable while select is high
  always_comb begin
    frame_done = cs_s_q & ~cs_d_q;
    take = frame_done & (rx_count == FRAME_COUNT) & key_sw_s;
    cmd = rx_word[CMD_HI:CMD_LO];
    addr = rx_word[ADDR_HI:ADDR_LO];
    wdata = rx_word[DATA_HI:0];
    stat_wr = take & (cmd == CMD_WR_STAT);
  end

  // Configuration bank, masked so absent bits stay zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        cfg_q[i] <= CFG_RESET[i];
      end
    end else if (take && cmd == CMD_WR_CFG) begin
      cfg_q[addr] <= wdata & CFG_MASK[addr];
    end
  end

  // Control bank
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        ctrl_q[i] <= 8'h00;
      end
    end else if (take && cmd == CMD_WR_CTRL) begin
      ctrl_q[addr] <= wdata & CTRL_MASK[addr];
    end
  end

  // Sticky fault bits, one status register per output
  generate
    for (genvar k = 0; k < NOUT; k++) begin : g_flt
      logic [3:0] set_v;
      logic [3:0] base_v;
      logic [3:0] wbits;
      logic sink_en;
      always_comb begin
        sink_en = cfg_q[OUT_ADDR[k]][CFG_SINK_EN];
        wbits = wdata[3:0];
        set_v = '0;
        set_v[FLT_OL] = ~on_s[k] & dlow_s[k];
        set_v[FLT_OC] = oc_s[k] | (on_s[k] & dhigh_s[k]);
        set_v[FLT_OT] = ot_s[k];
        set_v[FLT_SG] = sg_s[k];
        base_v = flt_q[k];
        if (stat_wr && addr == OUT_ADDR[k]) begin
          if (self_test_s) begin
            base_v = wbits;
          end else begin
            base_v = flt_q[k] & ~wbits;
          end
        end
      end
      // Set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
        if (!rst_b || any_reset_s) begin
          flt_q[k] <= 4'h0;
        end else begin
          flt_q[k] <= (base_v | set_v) & OUT_FLT_MASK[k] & {3'b111, sink_en};
        end
      end
    end
  endgenerate

  // On/off indicator conditions per annunciated output
  generate
    for (genvar i = 0; i < NIND; i++) begin : g_ind
      localparam int K = IND_OUT[i];
      logic [7:0] cfg_v;
      logic [7:0] ctl_v;
      logic commanded;
      logic pwm_ok;
      logic state_ok;
      always_comb begin
        cfg_v = cfg_q[OUT_ADDR[K]];
        ctl_v = ctrl_q[OUT_ADDR[K]];
        if (cfg_v[CFG_OR_AND]) begin
          commanded = cmd_pin_s[i] & ctl_v[CTRL_ON];
        end else begin
          commanded = cmd_pin_s[i] | ctl_v[CTRL_ON];
        end
        pwm_ok = (cfg_v[CFG_PWM_HI:0] == 2'b00) || (ctl_v[CTRL_DUTY_HI:0] != 7'h00);
        state_ok = key_sw_s;
        if (OUT_ADDR[K] == RELAY2_CFG) begin
          state_ok = key_sw_s | (pre_shut_s & cfg_v[CFG_SDD] & power_hold_s);
        end
        ind_d[i] = commanded & pwm_ok & state_ok & ~any_reset_s
                   & ~flt_q[K][FLT_OC] & ~flt_q[K][FLT_OT];
      end
    end
  endgenerate

  // Indicator flip-flops, set and cleared by device logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ind_q <= '0;
    end else begin
      ind_q <= ind_d;
    end
  end

  // System-wide summary flip-flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sys_any_q <= 1'b0;
    end else begin
      sys_any_q <= sys_any_d;
    end
  end

  // Status read value; summaries derived from held bits
  always_comb begin
    stat_rd = 8'h00;
    sys_any_d = 1'b0;
    for (int k = 0; k < NOUT; k++) begin
      sys_any_d = sys_any_d | (|flt_q[k]);
      if (addr == OUT_ADDR[k]) begin
        stat_rd = {|flt_q[k], 3'b000, flt_q[k]};
      end
    end
    if (addr == STAT_IND) begin
      stat_rd = ind_q;
    end
    if (addr == STAT_SYS) begin
      stat_rd = 8'h00;
      stat_rd[ANY_BIT] = sys_any_d;
    end
    if (addr == STAT_ID) begin
      stat_rd = {1'b0, MODEL_CODE, REVISION};
    end
  end

  // Value returned for the command just taken
  always_comb begin
    unique case (cmd)
      CMD_RD_CFG, CMD_WR_CFG: rd_val = cfg_q[addr];
      CMD_RD_STAT, CMD_WR_STAT: rd_val = stat_rd;
      CMD_RD_CTRL, CMD_WR_CTRL: rd_val = ctrl_q[addr];
      default: rd_val = 8'h00;
    endcase
    if (cmd == CMD_WR_CFG) begin
      rd_val = wdata & CFG_MASK[addr];
    end
    if (cmd == CMD_WR_CTRL) begin
      rd_val = wdata & CTRL_MASK[addr];
    end
    if (cmd == CMD_CHECK) begin
      resp_d = {CMD_CHECK_RESP, rx_word[PAYLOAD_HI:0]};
    end else if (cmd <= CMD_WR_CTRL) begin
      resp_d = {cmd, addr, rd_val};
    end else begin
      resp_d = 16'h0000;
    end
  end

  // Response word shifted out during the next frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp_q <= 16'h0000;
    end else if (take) begin
      resp_q <= resp_d;
    end
  end

  assign on_indicator = ind_q;
  assign system_any_fault = sys_any_q;
endmodule
`default_nettype wire

// ===== src/sfsrb_pkg.sv
// Purpose: Shared constants for the SPI fault and status register bank.
// Assumes: 16-bit frames, 8-bit registers, nine driven outputs.
// Notes: Output index 0..8 is inj1, inj2, relay1, relay2, tacho, lamp,
//        o2 heater, ign1, ign2.
package sfsrb_pkg;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 12;
  localparam int ADDR_HI = 11;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int PAYLOAD_HI = 11;
  localparam logic [4:0] FRAME_COUNT = 5'h10;
  localparam logic [3:0] LAST_BIT = 4'hF;

  // Command codes
  localparam logic [3:0] CMD_CHECK = 4'h0;
  localparam logic [3:0] CMD_RD_CFG = 4'h1;
  localparam logic [3:0] CMD_WR_CFG = 4'h2;
  localparam logic [3:0] CMD_RD_STAT = 4'h3;
  localparam logic [3:0] CMD_WR_STAT = 4'h4;
  localparam logic [3:0] CMD_RD_CTRL = 4'h5;
  localparam logic [3:0] CMD_WR_CTRL = 4'h6;
  localparam logic [3:0] CMD_CHECK_RESP = 4'h7;

  // Register bank shape
  localparam int NREG = 16;
  localparam int NOUT = 9;
  localparam int NIND = 8;
  localparam int NASYNC = 7 + NIND + 6 * NOUT;

  // Configuration register fields
  localparam int CFG_SINK_EN = 4;
  localparam int CFG_OR_AND = 2;
  localparam int CFG_PWM_HI = 1;
  localparam int CFG_SDD = 6;
  localparam logic [3:0] RELAY2_CFG = 4'h3;

  // Control register fields
  localparam int CTRL_ON = 7;
  localparam int CTRL_DUTY_HI = 6;

  // Status register layout
  localparam int FLT_OL = 0;
  localparam int FLT_OC = 1;
  localparam int FLT_OT = 2;
  localparam int FLT_SG = 3;
  localparam int ANY_BIT = 7;
  localparam logic [3:0] STAT_IND = 4'hC;
  localparam logic [3:0] STAT_SYS = 4'hD;
  localparam logic [3:0] STAT_ID = 4'hF;

  // Identity fields; the values are arbitrary
  localparam logic [2:0] MODEL_CODE = 3'h5;
  localparam logic [3:0] REVISION = 4'h2;

  localparam logic [7:0] CFG_RESET [NREG] = '{
    8'h10, 8'h10, 8'h18, 8'h10, 8'h01, 8'h18, 8'h00, 8'h10,
    8'h80, 8'h80, 8'hCA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CFG_MASK [NREG] = '{
    8'h9F, 8'h9F, 8'h9F, 8'hDF, 8'hFF, 8'h9B, 8'h83, 8'hD7,
    8'hD7, 8'hD7, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_MASK [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  // Register address of each output, implemented fault bits
  localparam logic [3:0] OUT_ADDR [NOUT] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
  localparam logic [3:0] OUT_FLT_MASK [NOUT] = '{
    4'hF, 4'hF, 4'hF, 4'hF, 4'h7, 4'hF, 4'h3, 4'h3, 4'h3};
  // Output index behind each on/off indicator bit (tacho has none)
  localparam int IND_OUT [NIND] = '{0, 1, 2, 3, 5, 6, 7, 8};
endpackage

// ===== src/sfsrb_spi_link.sv
// Purpose: Link-clock shifter for 16-bit frames, MSB first.
// Assumes: Sample on rising link clock; resp_word stable during a frame.
// Notes: link_clr comes from the core clock and clears the bit count.
`timescale 1ns/1ps
`default_nettype none
module sfsrb_spi_link (
  input wire logic link_clk,
  input wire logic link_clr,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic [15:0] resp_word,
  output logic [15:0] rx_word,
  output logic [4:0] rx_count,
  output logic miso
);
  import sfsrb_pkg::*;

  logic [15:0] rx_q;
  logic [4:0] cnt_q;

  // Shift in host bits, MSB first
  always_ff @(posedge link_clk) begin
    if (!chip_select_n && cnt_q < FRAME_COUNT) begin
      rx_q <= {rx_q[14:0], mosi};
    end
  end

  // Bit count; saturates at 16 so the extra bits of a long frame are ignored
  always_ff @(posedge link_clk or posedge link_clr) begin
    if (link_clr) begin
      cnt_q <= 5'h00;
    end else if (!chip_select_n && cnt_q < FRAME_COUNT) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Response bit for the current position, same edges as input
  always_comb begin
    miso = 1'b0;
    if (cnt_q < FRAME_COUNT) begin
      miso = resp_word[LAST_BIT - cnt_q[3:0]];
    end
  end

  assign rx_word = rx_q;
  assign rx_count = cnt_q;
endmodule
`default_nettype wire
